// [bench/mmd_assertions.sv]
// bus-level assertions between master and decoder
module mmd_checker (
  input wire logic        CLK_I,              // clock
  input wire logic        RESET_I,            // sync reset
  input wire logic        req,                // request
  input wire logic        we,                 // write
  input wire logic        byte_acc,           // byte access
  input wire logic        fetch,              // fetch
  input wire logic [15:0] memory_address_bus, // address
  input wire logic [15:0] memory_data_bus,    // read data
  input wire logic        ack                 // answer
);
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  // handshake: answer next cycle, one pulse, bus quiet after
  property p_ack_next; req && !ack |=> ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_req_quiet; ack |-> !req [*3]; endproperty
  a_req_quiet: assert property (p_req_quiet) else $error("overlapping access");
  // alignment of fetches and words
  property p_fetch_even; req && fetch |-> !memory_address_bus[0]; endproperty
  a_fetch_even: assert property (p_fetch_even) else $error("odd fetch");
  property p_word_even; req && !byte_acc |-> !memory_address_bus[0]; endproperty
  a_word_even: assert property (p_word_even) else $error("odd word");
  // read data shape in the answer cycle
  property p_byte_hi; req && !ack && !we && byte_acc |=> memory_data_bus[15:8] == 8'h00;
  endproperty
  a_byte_hi: assert property (p_byte_hi) else $error("byte upper set");
  property p_wper_hi; req && !ack && !we && byte_acc && memory_address_bus[15:8] == 8'h01
    |=> memory_data_bus[15:8] == 8'h00; endproperty
  a_wper_hi: assert property (p_wper_hi) else $error("word periph upper set");
  property p_unm_zero; req && !ack && !we && memory_address_bus inside {[16'h0a00:16'hbfff]}
    |=> memory_data_bus == 16'h0000; endproperty
  a_unm_zero: assert property (p_unm_zero) else $error("unmapped read nonzero");
endmodule : mmd_checker

// [bench/test_memory_map_decoder.sv]
// self-checking bench: master and decoder joined by the bus
module test_memory_map_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import mmd_pkg::*;
  typedef struct {mmd_region_t r; logic [15:0] d, m, ad, wd; logic [2:0] wb;
                  logic v;} mmd_note_t;
  logic CLK_I = 1'b0, RESET_I = 1'b1, start = 1'b0, we_i = 1'b0, byte_i = 1'b0, fetch_i = 1'b0;
  logic ready, done, we_o, rb;
  logic [1:0] be_o;
  logic [2:0] wb_seen;
  wire  [4:0] sel_o;
  logic [4:0] sel_seen;
  logic vec_o, vh_seen;
  logic [15:0] addr_o, wdo, ad_seen, wd_seen;
  logic [15:0] addr_i = 16'h0000, wdata_i = 16'h0000, rdata, ra;
  logic [15:0] rd [6] = '{default: 16'h0000}; // slot 0 stands for unmapped
  logic [15:0] tbl [12] = '{16'h000f, 16'h0010, 16'h00ff, 16'h0100, 16'h01fe, 16'h0200,
                            16'h09ff, 16'h0a00, 16'hbfff, 16'hc000, 16'hffe1, 16'hfffe};
  mmd_region_t region, r_seen;
  mmd_note_t q [$];
  mmd_note_t n;
  int fail_count = 0, checks = 0, cyc = 0;
  always #5 CLK_I = ~CLK_I;
  mmd_bus_if mmd_bus_if_inst ();
  mmd_master mmd_master_inst (.CLK_I(CLK_I), .RESET_I(RESET_I), .BUS(mmd_bus_if_inst),
    .START_I(start), .WE_I(we_i), .BYTE_I(byte_i), .FETCH_I(fetch_i), .ADDR_I(addr_i),
    .WDATA_I(wdata_i), .READY_O(ready), .DONE_O(done), .RDATA_O(rdata));
  mmd_decoder mmd_decoder_inst (.CLK_I(CLK_I), .RESET_I(RESET_I), .BUS(mmd_bus_if_inst),
    .REGION_O(region), .ADDR_O(addr_o), .SFR_SEL_O(sel_o[0]), .BPER_SEL_O(sel_o[1]),
    .WPER_SEL_O(sel_o[2]), .RAM_SEL_O(sel_o[3]), .ROM_SEL_O(sel_o[4]), .VEC_HIT_O(vec_o),
    .WE_O(we_o), .BE_O(be_o), .WDATA_O(wdo), .SFR_RDATA_I(rd[1]),
    .BPER_RDATA_I(rd[2]), .WPER_RDATA_I(rd[3]), .RAM_RDATA_I(rd[4]), .ROM_RDATA_I(rd[5]));
  mmd_checker mmd_checker_inst (.CLK_I(CLK_I), .RESET_I(RESET_I), .req(mmd_bus_if_inst.req),
    .we(mmd_bus_if_inst.we), .byte_acc(mmd_bus_if_inst.byte_acc), .fetch(mmd_bus_if_inst.fetch),
    .memory_address_bus(mmd_bus_if_inst.memory_address_bus), .ack(mmd_bus_if_inst.ack),
    .memory_data_bus(mmd_bus_if_inst.memory_data_bus));
  // priority order guards against overlapping ranges
  function automatic mmd_region_t rgn_of(input logic [15:0] a);
    if (a <= 16'h000f) return MMD_RGN_SFR;
    if (a <= 16'h00ff) return MMD_RGN_BPER;
    if (a <= 16'h01ff) return MMD_RGN_WPER;
    if (a <= 16'h09ff) return MMD_RGN_RAM;
    return (a >= 16'hc000) ? MMD_RGN_ROM : MMD_RGN_NONE;
  endfunction : rgn_of
  task automatic cmp_data(input logic [15:0] g, e, m);
    checks++;
    if ((g & m) !== (e & m))
    begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, g & m, e & m);
    end
  endtask : cmp_data
  task automatic cmp_sel(input logic [8:0] g, e);
    cmp_data({7'h00, g}, {7'h00, e}, 16'h01ff);
  endtask : cmp_sel
  task automatic wrap_up();
    if (q.size() != 0) fail_count++;  // an access that never completed
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // one access: note the expectation, launch, wait for completion
  task automatic access(input logic w, b, f, input logic [15:0] a);
    mmd_note_t x;
    logic lo, hi;
    logic [15:0] wv;
    for (int i = 1; i < 6; i++) rd[i] = 16'($urandom);
    wv = 16'($urandom);
    x.r = rgn_of(a);
    lo = x.r inside {MMD_RGN_SFR, MMD_RGN_BPER}; // narrow targets sit on the low lane
    hi = b && !f && a[0] && !lo;
    x.d = hi ? {8'h00, rd[$clog2(x.r)][15:8]} :
          b  ? {8'h00, rd[$clog2(x.r)][7:0]} : rd[$clog2(x.r)];
    x.ad = (b && !f) ? a : {a[15:1], 1'b0};  // words and fetches aligned
    x.v = x.ad >= 16'hffe0;
    x.wd = hi ? {wv[7:0], 8'h00} : wv;
    x.m = w ? 16'h0000 : (!b && x.r == MMD_RGN_BPER) ? 16'h00ff : 16'hffff; // upper undefined
    x.wb = (x.r == MMD_RGN_NONE) ? 3'b000 : {w, (lo || b) ? {hi, !hi} : 2'b11};
    q.push_back(x);
    {we_i, byte_i, fetch_i, addr_i, wdata_i, start} = {w, b, f, a, wv, 1'b1};
    @(negedge CLK_I) start = 1'b0;
    repeat (6) if (done !== 1'b1) @(negedge CLK_I);
    @(negedge CLK_I);
  endtask : access
  // watcher: lanes at request time, data at completion
  always @(posedge CLK_I)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      wrap_up();
    end
    if (mmd_bus_if_inst.req === 1'b1 && mmd_bus_if_inst.ack === 1'b0)
    begin
      r_seen = region;
      wb_seen = {we_o, be_o};
      {sel_seen, vh_seen, ad_seen, wd_seen} = {sel_o, vec_o, addr_o, wdo};
    end
    if (done === 1'b1 && q.size() > 0)
    begin
      n = q.pop_front();
      cmp_sel({r_seen, n.r == MMD_RGN_NONE ? 3'b000 : wb_seen}, {n.r, n.wb});
      cmp_data(rdata, n.d, n.m);
      cmp_sel({sel_seen, 1'b0, vh_seen, 2'b00}, {n.r & 6'h3e, n.v, 2'b00});
      cmp_data(ad_seen, n.ad, 16'hffff);
      cmp_data(wd_seen, n.wd, 16'hffff);
    end
  end
  // boundaries first, then random traffic within legal use
  initial
  begin
    void'($urandom(32));
    repeat (10) @(negedge CLK_I);
    RESET_I = 1'b0;
    foreach (tbl[i])
    begin
      access(1'b0, 1'b1, 1'b0, tbl[i]);
      if (tbl[i] > 16'h000f) access(1'b0, 1'b0, 1'b0, tbl[i]);
      access(1'b1, tbl[i] < 16'h0010, 1'b0, tbl[i]);
    end
    access(1'b0, 1'b0, 1'b1, 16'hc003);
    // mid-run reset: both ends must come back idle with the bus read data cleared
    RESET_I = 1'b1;
    repeat (2) @(negedge CLK_I);
    cmp_sel({ready, done, mmd_bus_if_inst.ack, mmd_bus_if_inst.req, 5'h00}, 9'h100);
    cmp_data(mmd_bus_if_inst.memory_data_bus, 16'h0000, 16'hffff);
    RESET_I = 1'b0;
    repeat (40)
    begin
      {ra, rb} = {16'($urandom), 1'($urandom)};
      if (ra < 16'h0010) rb = 1'b1;
      if (ra[15:8] == 8'h01 && rb) ra[0] = 1'b0;
      access(1'($urandom), rb, 1'b0, ra);
    end
    wrap_up();
  end
endmodule : test_memory_map_decoder

// [hdl/mmd_decoder.sv]
// memory map decoder: routes master accesses to the five regions

`include "mmd_regs.svh"

// address map, low to high, with the default sizes
//   0000-000f  special function registers, one byte each
//   0010-00ff  byte peripherals
//   0100-01ff  word peripherals
//   0200-09ff  ram, end set by RAM_LAST
//   0a00-bfff  unmapped: reads give zero, writes select nothing
//   c000-ffff  flash, start set by ROM_FIRST
//   ffe0-ffff  vector table, top sixteen words of flash
// the whole 16-bit space is decoded; only bit 0 of word accesses and fetches is ignored
// should the parameters make ranges overlap, the lower region wins

// parameters
//   RAM_LAST: last ram byte, grows with the fitted ram
//   ROM_FIRST: first flash byte, falls as more flash is fitted

// lane use
//   word access outside the byte regions: both lanes, low byte at the even address
//   byte access outside the byte regions: lane from address bit 0
//   special regs and byte periph: low lane for every byte address,
//   as each byte address there is a register of its own

// write handling
//   word write to a byte region enables the low lane only
//   an odd byte write elsewhere has its data moved to the high lane
//   a fetch never raises the write strobe

// timing of one access
//   cycle 1: req high; selects, lanes, strobe and write data valid
//   cycle 2: ack high for one cycle, read data registered
//   cycle 3: master shows done and the read result
//   the master drops req in the ack cycle; a new access may follow
//   from cycle 5, after the done cycle and one idle cycle

// reset clears ack and read data; a request may follow at once

// limitations
//   targets answer in the select cycle, there are no wait states
//   no error answer: software must keep to the mapped ranges
//   an odd byte read of a word peripheral is passed on as it is
//   a word read of a byte peripheral returns the target's upper byte
//   selects are combinational, so targets see them in the request cycle

module mmd_decoder
  import mmd_pkg::*;
#(
  parameter logic [15:0] RAM_LAST  = `MMD_RAM_LAST,
  parameter logic [15:0] ROM_FIRST = `MMD_ROM_FIRST
)(
  input  wire logic        CLK_I,         // system clock
  input  wire logic        RESET_I,       // sync reset, high
  mmd_bus_if.decoder       BUS,           // master side
  output      mmd_pkg::mmd_region_t REGION_O,  // decoded region of access
  output      logic [15:0] ADDR_O,        // aligned address to targets
  output      logic        SFR_SEL_O,     // special regs select
  output      logic        BPER_SEL_O,    // byte peripheral select
  output      logic        WPER_SEL_O,    // word peripheral select
  output      logic        RAM_SEL_O,     // ram select
  output      logic        ROM_SEL_O,     // flash select
  output      logic        VEC_HIT_O,     // access in vector table
  output      logic        WE_O,          // write strobe to target
  output      logic [1:0]  BE_O,          // byte lanes {hi,lo}
  output      logic [15:0] WDATA_O,       // lane-steered write data
  input  wire logic [15:0] SFR_RDATA_I,   // special regs read data
  input  wire logic [15:0] BPER_RDATA_I,  // byte peripheral read data
  input  wire logic [15:0] WPER_RDATA_I,  // word peripheral read data
  input  wire logic [15:0] RAM_RDATA_I,   // ram read data
  input  wire logic [15:0] ROM_RDATA_I    // flash read data
);
  import mmd_pkg::*;

  // address as seen by the targets; words and fetches always aligned,
  // so an odd word address reaches the same word as its even neighbour
  wire logic        force_even = ~BUS.byte_acc | BUS.fetch;
  wire logic        bit0       = BUS.memory_address_bus[0] & ~force_even;
  wire logic [15:0] a          = {BUS.memory_address_bus[15:1], bit0};
  wire logic        odd        = a[0];

  // inclusive range test, shared by every bounded region but the special regs
  function automatic logic in_span(input logic [15:0] x,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    return x >= lo && x <= hi;
  endfunction : in_span

  // range decode, 16-bit compares cover the 64 KB space
  wire logic in_sfr  = a <= `MMD_SFR_LAST;
  wire logic in_bper = in_span(a, `MMD_BPER_FIRST, `MMD_BPER_LAST);
  wire logic in_wper = in_span(a, `MMD_WPER_FIRST, `MMD_WPER_LAST);
  wire logic in_ram  = in_span(a, `MMD_RAM_FIRST, RAM_LAST);
  wire logic in_rom  = in_span(a, ROM_FIRST, `MMD_ROM_LAST);
  wire logic in_vec  = in_span(a, `MMD_VEC_FIRST, `MMD_ROM_LAST);

  // priority encode keeps the selects exclusive
  wire mmd_region_t region = in_sfr  ? MMD_RGN_SFR  :
                             in_bper ? MMD_RGN_BPER :
                             in_wper ? MMD_RGN_WPER :
                             in_ram  ? MMD_RGN_RAM  :
                             in_rom  ? MMD_RGN_ROM  : MMD_RGN_NONE;

  // byte lanes: byte regions always take the low lane only
  wire logic        narrow  = region == MMD_RGN_SFR || region == MMD_RGN_BPER;
  // the high lane serves only an odd byte outside the byte regions
  wire logic        hi_lane = BUS.byte_acc && odd && !narrow;
  wire logic [1:0]  be      = narrow        ? 2'b01 :
                              !BUS.byte_acc ? 2'b11 :
                              hi_lane       ? 2'b10 : 2'b01;
  // byte data sits on the lane that its address selects
  wire logic [15:0] wdata   = hi_lane ? {BUS.wdata[7:0], 8'h00} : BUS.wdata;

  // read data mux; unmapped reads give zero
  logic [15:0] raw;
  always_comb
  begin
    unique case (region)
      MMD_RGN_SFR:  raw = SFR_RDATA_I;
      MMD_RGN_BPER: raw = BPER_RDATA_I;
      MMD_RGN_WPER: raw = WPER_RDATA_I;
      MMD_RGN_RAM:  raw = RAM_RDATA_I;
      MMD_RGN_ROM:  raw = ROM_RDATA_I;
      default:      raw = 16'h0000;
    endcase
  end
  // byte reads return the addressed byte low, upper zero;
  // the byte regions give every byte on the low lane, as writes use it
  wire logic [15:0] rbyte = hi_lane ? {8'h00, raw[15:8]} : {8'h00, raw[7:0]};
  // word reads pass the target's word on untouched
  wire logic [15:0] rdata = BUS.byte_acc ? rbyte : raw;

  // region code and aligned address, combinational for the request cycle
  assign REGION_O   = BUS.req ? region : MMD_RGN_NONE;
  assign ADDR_O     = a;

  // one select per target from the one-hot code; none while idle
  wire  logic [5:0] region_bits = region;
  logic       [4:0] sel_vec;
  for (genvar g = 0; g < 5; g++)
  begin : g_sel
    assign sel_vec[g] = BUS.req && region_bits[g + 1];
  end
  assign SFR_SEL_O  = sel_vec[0];
  assign BPER_SEL_O = sel_vec[1];
  assign WPER_SEL_O = sel_vec[2];
  assign RAM_SEL_O  = sel_vec[3];
  assign ROM_SEL_O  = sel_vec[4];
  assign VEC_HIT_O  = BUS.req && in_vec;

  // strobes; a fetch never writes, idle cycles enable no lane
  assign WE_O       = BUS.req && BUS.we && !BUS.fetch;
  assign BE_O       = BUS.req ? be : 2'b00;
  assign WDATA_O    = wdata;

  // answer one cycle after the request; ack falls again at once so that
  // a request still held in the ack cycle is not taken twice
  logic        ack_ff;
  logic [15:0] rd_ff;
  wire  logic        nxt_ack = BUS.req && !ack_ff;
  // read data is kept until the next read, writes leave it alone
  wire  logic [15:0] nxt_rd  = (BUS.req && !BUS.we) ? rdata : rd_ff;

  // handshake flag
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= nxt_ack;
    end
  end

  // read data register; a data output, so it comes from a flip-flop
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      rd_ff <= 16'h0000;
    end
    else
    begin
      rd_ff <= nxt_rd;
    end
  end

  // bus answer
  assign BUS.ack             = ack_ff;
  assign BUS.memory_data_bus = rd_ff;
endmodule : mmd_decoder

// [hdl/mmd_master.sv]
// bus master end: turns user requests into aligned bus accesses
module mmd_master
  import mmd_pkg::*;
(
  input  wire logic        CLK_I,      // system clock
  input  wire logic        RESET_I,    // sync reset, high
  mmd_bus_if.master        BUS,        // decoder side
  input  wire logic        START_I,    // request pulse
  input  wire logic        WE_I,       // write
  input  wire logic        BYTE_I,     // byte access
  input  wire logic        FETCH_I,    // instruction fetch
  input  wire logic [15:0] ADDR_I,     // access address
  input  wire logic [15:0] WDATA_I,    // write data
  output      logic        READY_O,    // idle, may start
  output      logic        DONE_O,     // one-cycle completion
  output      logic [15:0] RDATA_O     // read result
);
  import mmd_pkg::*;

  mmd_mstate_t st_ff;
  logic        we_ff, byte_ff, fetch_ff, done_ff;
  logic [15:0] addr_ff, wd_ff, rd_ff;

  // fetches and word accesses go out at even addresses; byte data stays
  wire logic        aligned = ~BYTE_I | FETCH_I;
  wire logic [15:0] nxt_addr = {ADDR_I[15:1], ADDR_I[0] & ~aligned};
  wire logic        go = st_ff == MMD_M_IDLE && START_I;

  // sequence: idle, hold request until ack, one done cycle
  mmd_mstate_t nxt_st;
  always_comb
  begin
    unique case (st_ff)
      MMD_M_IDLE: nxt_st = START_I ? MMD_M_REQ : MMD_M_IDLE;
      MMD_M_REQ:  nxt_st = BUS.ack ? MMD_M_DONE : MMD_M_REQ;
      MMD_M_DONE: nxt_st = MMD_M_IDLE;
      default:    nxt_st = MMD_M_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      st_ff <= MMD_M_IDLE; we_ff <= 1'b0; byte_ff <= 1'b0; fetch_ff <= 1'b0;
      addr_ff <= 16'h0000; wd_ff <= 16'h0000; rd_ff <= 16'h0000; done_ff <= 1'b0;
    end
    else
    begin
      st_ff   <= nxt_st;
      done_ff <= st_ff == MMD_M_REQ && BUS.ack;
      if (go)
      begin
        we_ff <= WE_I & ~FETCH_I; byte_ff <= BYTE_I; fetch_ff <= FETCH_I;
        addr_ff <= nxt_addr; wd_ff <= WDATA_I;
      end
      if (st_ff == MMD_M_REQ && BUS.ack)
        rd_ff <= BUS.memory_data_bus;
    end
  end

  // one shared bus, request held until answered
  assign BUS.req                = st_ff == MMD_M_REQ && !BUS.ack;
  assign BUS.we                 = we_ff;
  assign BUS.byte_acc           = byte_ff;
  assign BUS.fetch              = fetch_ff;
  assign BUS.memory_address_bus = addr_ff;
  assign BUS.wdata              = wd_ff;
  assign READY_O                = st_ff == MMD_M_IDLE;
  assign DONE_O                 = done_ff;
  assign RDATA_O                = rd_ff;
endmodule : mmd_master

// [pkg/mmd_bus_if.sv]
// shared memory bus between master and decoder
interface mmd_bus_if;
  logic        req;       // access request, level
  logic        we;        // write
  logic        byte_acc;  // byte access when high
  logic        fetch;     // instruction fetch
  logic [15:0] memory_address_bus;
  logic [15:0] wdata;     // master write data
  logic [15:0] memory_data_bus;  // read data to master
  logic        ack;       // one-cycle answer
  modport master (output req, we, byte_acc, fetch, memory_address_bus, wdata,
                  input memory_data_bus, ack);
  modport decoder (input req, we, byte_acc, fetch, memory_address_bus, wdata,
                   output memory_data_bus, ack);
endinterface : mmd_bus_if

// [pkg/mmd_pkg.sv]
// types shared by both ends of the memory map decoder
package mmd_pkg;
  typedef enum logic [5:0] {
    MMD_RGN_NONE = 6'b000001,
    MMD_RGN_SFR  = 6'b000010,
    MMD_RGN_BPER = 6'b000100,
    MMD_RGN_WPER = 6'b001000,
    MMD_RGN_RAM  = 6'b010000,
    MMD_RGN_ROM  = 6'b100000
  } mmd_region_t;
  typedef enum logic [2:0] {
    MMD_M_IDLE = 3'b001,
    MMD_M_REQ  = 3'b010,
    MMD_M_DONE = 3'b100
  } mmd_mstate_t;
endpackage : mmd_pkg

// [pkg/mmd_regs.svh]
// address map constants for the memory map decoder
`ifndef MMD_REGS_SVH
`define MMD_REGS_SVH
`define MMD_ADDR_W      16
`define MMD_DATA_W      16
`define MMD_SFR_LAST    16'h000f
`define MMD_BPER_FIRST  16'h0010
`define MMD_BPER_LAST   16'h00ff
`define MMD_WPER_FIRST  16'h0100
`define MMD_WPER_LAST   16'h01ff
`define MMD_RAM_FIRST   16'h0200
`define MMD_RAM_LAST    16'h09ff
`define MMD_ROM_FIRST   16'hc000
`define MMD_ROM_LAST    16'hffff
`define MMD_VEC_FIRST   16'hffe0
`define MMD_VEC_RESET   16'hfffe
`define MMD_VEC_WORDS   16
`endif
